// ===== core/uss_core.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Contract
// RULE_01: Slave mode from sync, enable, clear source
// RULE_02: Ninth received bit lands in status
// RULE_03: Receive done flag; interrupt needs enable
// RULE_04: Low byte at FIFO head; read pops
// RULE_05: Overrun clears on receive or port disable
// RULE_06: Shifting only in slave mode, sleep too
// RULE_07: Shift stages advance only on master clock
// RULE_08: Receive flag clears when FIFO emptied
// RULE_09: Receive while asleep, flag requests wake
// RULE_10: Wake with global enable calls vector
// RULE_11: Holding write clears empty flag, moves on
// RULE_12: Transmit bits shift on master clock edges
// RULE_13: After word, reload stage then flag empty
// RULE_14: Transmit wake needs both enables set
// RULE_15: Pins selectable between two locations
// RULE_16: Slave receive never idle; single enable ignored
// RULE_17: Full FIFO plus new word sets overrun
module uss_core #(
  parameter int FIFO_DEPTH = uss_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core state and requests
  input wire logic core_sleep,
  output logic irq,
  output logic wake_req,
  output logic isr_call,
  output logic [11:0] isr_vector,
  // Shift clock pin, two locations
  input wire logic ck_a_in,
  input wire logic ck_b_in,
  // Data pin, two locations
  input wire logic dt_a_in,
  input wire logic dt_b_in,
  output logic dt_a_out,
  output logic dt_a_oe,
  output logic dt_b_out,
  output logic dt_b_oe
);

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] baud_control;            // Polarity bit is writable
  logic [7:0] receive_status_control;  // Writable control bits only
  logic [7:0] transmit_status_control; // Writable control bits only
  logic [7:0] int_enable;              // Receive, transmit, peripheral, global
  logic [7:0] alternate_pin_select_a;  // Data pin location
  logic [7:0] alternate_pin_select_b;  // Clock pin location
  logic [2:0] evt_status;              // Sticky events
  logic [2:0] evt_mask;                // Event gates onto irq
  logic [3:0] pin_meta;                // First synchroniser stage
  logic [3:0] pin_sync;                // Second synchroniser stage
  logic ck_level;                      // Selected clock, polarity applied
  logic ck_prev;                       // Clock level one cycle ago
  logic ck_lead;                       // Leading shift clock edge
  logic ck_trail;                      // Trailing shift clock edge
  logic dt_level;                      // Selected data pin level
  logic serial_port_enable;
  logic slave_mode;
  logic continuous_receive_enable;
  logic rx_en;                         // Receiver armed
  logic tx_mode;                       // Transmitter armed
  logic shift_allowed;                 // Shift clock usable in this state
  logic [8:0] rx_shift;                // receive_shift_stage
  logic [3:0] rx_cnt;                  // Bits taken so far
  logic [3:0] rx_len;                  // Bits per received word
  logic rx_done;                       // One-cycle word complete
  uss_pkg::uss_word_t rx_word;         // Word just completed
  uss_pkg::uss_word_t next_rx_word;    // Word as the last bit arrives
  uss_pkg::uss_word_t fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] fifo_cnt;
  logic fifo_full;
  logic fifo_pop;                      // Read of receive buffer
  logic fifo_push;                     // Word accepted into FIFO
  logic overrun;                       // Word lost to full FIFO
  logic overrun_error_flag;
  logic receive_done_flag;
  logic transmit_empty_flag;
  logic hold_wr;                       // Write to holding buffer
  logic hold_full;
  uss_pkg::uss_word_t transmit_holding_buffer;
  logic [8:0] transmit_shift_stage;
  logic [3:0] tx_cnt;                  // Bits sent so far
  logic [3:0] tx_len;                  // Bits in current word
  logic tx_busy;
  logic tx_load;                       // Holding buffer moves to stage
  logic dt_drive;                      // Data pin driven by us
  logic [7:0] next_rdata;

  // Pointer step with wrap
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  // Address match with a strobe; address passed in so assigns follow it
  function automatic logic hit(input logic stb, input logic [3:0] a,
                               input logic [3:0] ofs);
    hit = stb && (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign serial_port_enable = receive_status_control[uss_pkg::BIT_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable =
    receive_status_control[uss_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
  // Slave needs sync, port enable and external clock source [RULE_01]
  assign slave_mode = serial_port_enable &&
    transmit_status_control[uss_pkg::BIT_SYNC] &&
    !transmit_status_control[uss_pkg::BIT_CLOCK_SOURCE_SELECT];
  // Sleep stops every mode but slave, whose clock is external [RULE_06]
  assign shift_allowed = slave_mode || !core_sleep;
  // Only continuous enable arms the receiver; single enable ignored
  assign rx_en = shift_allowed && slave_mode &&
    continuous_receive_enable && !overrun_error_flag; // [RULE_01] [RULE_16]
  // Transmit needs both receive enables clear; sleep does not stop it
  assign tx_mode = shift_allowed && slave_mode
    && transmit_status_control[uss_pkg::BIT_TXEN]
    && !continuous_receive_enable
    && !receive_status_control[uss_pkg::BIT_SINGLE_RECEIVE_ENABLE]; // [RULE_06]

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= (gi == 0) ? ck_a_in : (gi == 1) ? ck_b_in :
                          (gi == 2) ? dt_a_in : dt_b_in;
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Location choice after synchronising [RULE_15]
  assign ck_level = (alternate_pin_select_b[uss_pkg::BIT_TXCK_SEL] ?
    pin_sync[1] : pin_sync[0]) ^ baud_control[uss_pkg::BIT_SCK_POL];
  assign dt_level = alternate_pin_select_a[uss_pkg::BIT_RXDT_SEL] ?
    pin_sync[3] : pin_sync[2];

  // Edge finder on the master's clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev <= 1'b0;
    end else begin
      ck_prev <= ck_level;
    end
  end
  assign ck_lead = ck_level && !ck_prev;
  assign ck_trail = !ck_level && ck_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Receive shift stage, sampled on leading edges
  assign rx_len = receive_status_control[uss_pkg::BIT_RX9] ?
    uss_pkg::LEN_NINE : uss_pkg::LEN_BYTE;

  always_comb begin
    // Nine-bit words split low byte and top bit [RULE_02]
    if (receive_status_control[uss_pkg::BIT_RX9]) begin
      next_rx_word = {dt_level, rx_shift[8:1]};
    end else begin
      next_rx_word = {1'b0, dt_level, rx_shift[8:2]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 9'h000;
      rx_cnt <= 4'h0;
      rx_done <= 1'b0;
      rx_word <= '0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_en) begin
        // Disarmed: drop partial word
        rx_cnt <= 4'h0;
      end else if (ck_lead) begin
        // Master clock alone advances it, awake or asleep [RULE_07] [RULE_09]
        rx_shift <= {dt_level, rx_shift[8:1]};
        if (rx_cnt == rx_len - 4'h1) begin
          rx_cnt <= 4'h0;
          rx_done <= 1'b1;
          rx_word <= next_rx_word;
        end else begin
          rx_cnt <= rx_cnt + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO
  assign fifo_full = (fifo_cnt == CW'(FIFO_DEPTH));
  assign fifo_pop = hit(reg_rd, reg_addr, uss_pkg::OFS_RX_BUFFER) &&
    (fifo_cnt != '0);
  // Full FIFO with no pop discards the new word [RULE_17]
  assign overrun = rx_done && fifo_full && !fifo_pop;
  assign fifo_push = rx_done && !overrun;
  // Flag follows FIFO content, clears once emptied [RULE_03] [RULE_08]
  assign receive_done_flag = (fifo_cnt != '0);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else if (!serial_port_enable) begin
      // Port disable resets the transceiver [RULE_05]
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else begin
      if (fifo_push) begin
        fifo_mem[wr_ptr] <= rx_word;
        wr_ptr <= ptr_inc(wr_ptr);
      end
      // Reading the buffer pops the head [RULE_04]
      if (fifo_pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (fifo_push && !fifo_pop) begin
        fifo_cnt <= fifo_cnt + 1'b1;
      end else if (fifo_pop && !fifo_push) begin
        fifo_cnt <= fifo_cnt - 1'b1;
      end
    end
  end

  // Overrun latch; disabling receive or the port clears it [RULE_05]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_error_flag <= 1'b0;
    end else if (!continuous_receive_enable || !serial_port_enable) begin
      overrun_error_flag <= 1'b0;
    end else if (overrun) begin
      overrun_error_flag <= 1'b1; // [RULE_17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding buffer and shift stage
  assign hold_wr = hit(reg_wr, reg_addr, uss_pkg::OFS_TX_HOLDING) &&
    serial_port_enable;
  assign tx_load = tx_mode && hold_full && !tx_busy;
  // Empty flag is the inverse of a pending byte [RULE_11] [RULE_13]
  assign transmit_empty_flag = !hold_full;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_full <= 1'b0;
      transmit_holding_buffer <= '0;
    end else if (!serial_port_enable) begin
      hold_full <= 1'b0;
    end else begin
      // A write fills the buffer even as the old byte leaves [RULE_11]
      hold_full <= hold_wr || (hold_full && !tx_load);
      if (hold_wr) begin
        transmit_holding_buffer <= {
          transmit_status_control[uss_pkg::BIT_TX9D], reg_wdata};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_shift_stage <= 9'h000;
      tx_cnt <= 4'h0;
      tx_len <= uss_pkg::LEN_BYTE;
      tx_busy <= 1'b0;
    end else if (!tx_mode) begin
      // Leaving transmit abandons the word in flight
      tx_busy <= 1'b0;
      tx_cnt <= 4'h0;
    end else if (tx_load) begin
      // Free stage takes the pending byte [RULE_11] [RULE_13]
      transmit_shift_stage <= transmit_holding_buffer;
      tx_len <= transmit_status_control[uss_pkg::BIT_TX9] ?
        uss_pkg::LEN_NINE : uss_pkg::LEN_BYTE;
      tx_cnt <= 4'h0;
      tx_busy <= 1'b1;
    end else if (tx_busy && ck_trail) begin
      // Next bit only on the master's trailing edge [RULE_07] [RULE_12]
      if (tx_cnt == tx_len - 4'h1) begin
        tx_busy <= 1'b0;
      end else begin
        transmit_shift_stage <= {1'b0, transmit_shift_stage[8:1]};
        tx_cnt <= tx_cnt + 4'h1;
      end
    end
  end

  // Data pin drive at the selected location [RULE_12] [RULE_15]
  assign dt_drive = tx_mode;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dt_a_out <= 1'b0;
      dt_a_oe <= 1'b0;
      dt_b_out <= 1'b0;
      dt_b_oe <= 1'b0;
    end else begin
      dt_a_out <= transmit_shift_stage[0];
      dt_b_out <= transmit_shift_stage[0];
      dt_a_oe <= dt_drive && !alternate_pin_select_a[uss_pkg::BIT_RXDT_SEL];
      dt_b_oe <= dt_drive && alternate_pin_select_a[uss_pkg::BIT_RXDT_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_control <= uss_pkg::RST_REG;
      receive_status_control <= uss_pkg::RST_REG;
      transmit_status_control <= uss_pkg::RST_REG;
      int_enable <= uss_pkg::RST_REG;
      evt_mask <= uss_pkg::RST_EVT;
      alternate_pin_select_a <= uss_pkg::RST_REG;
      alternate_pin_select_b <= uss_pkg::RST_REG;
    end else if (reg_wr) begin
      // Read-only positions stay zero in storage
      unique case (reg_addr)
        uss_pkg::OFS_BAUD_CONTROL: begin
          baud_control <= reg_wdata & 8'h10;
        end
        uss_pkg::OFS_RX_STATUS: begin
          receive_status_control <= reg_wdata & 8'hF0;
        end
        uss_pkg::OFS_TX_STATUS: begin
          transmit_status_control <= reg_wdata & 8'hF1;
        end
        uss_pkg::OFS_INT_ENABLE: begin
          int_enable <= reg_wdata & 8'h0F;
        end
        uss_pkg::OFS_EVT_MASK: begin
          evt_mask <= reg_wdata[2:0];
        end
        uss_pkg::OFS_ALT_PIN_A: begin
          alternate_pin_select_a <= reg_wdata & 8'h80;
        end
        uss_pkg::OFS_ALT_PIN_B: begin
          alternate_pin_select_b <= reg_wdata & 8'h01;
        end
        default: begin
          // Other offsets hold no control state
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear, a new event wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= uss_pkg::RST_EVT;
    end else begin
      evt_status <= (evt_status & ~({3{hit(reg_wr, reg_addr,
        uss_pkg::OFS_EVT_STATUS)}} & reg_wdata[2:0])) |
        {overrun, tx_load, fifo_push};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, wake and vector requests
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
      isr_call <= 1'b0;
      isr_vector <= 12'h000;
    end else begin
      irq <= |(evt_status & evt_mask);
      // Receive needs its enable; transmit needs two [RULE_03] [RULE_14]
      wake_req <= (receive_done_flag && int_enable[uss_pkg::BIT_RECEIVE_DONE_FLAG]) ||
        (transmit_empty_flag && int_enable[uss_pkg::BIT_TRANSMIT_EMPTY_FLAG] &&
         int_enable[uss_pkg::BIT_PERIPHERAL_INTERRUPT_ENABLE]); // [RULE_09]
      // Global enable turns the wake into a vectored call [RULE_10]
      isr_call <= wake_req && int_enable[uss_pkg::BIT_GIE];
      isr_vector <= (wake_req && int_enable[uss_pkg::BIT_GIE]) ?
        uss_pkg::ISR_VECTOR : 12'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      uss_pkg::OFS_BAUD_CONTROL: begin
        next_rdata = baud_control;
        next_rdata[uss_pkg::BIT_RX_IDLE] = !rx_en; // [RULE_16]
      end
      uss_pkg::OFS_RX_BUFFER: begin
        next_rdata = (fifo_cnt != '0) ? fifo_mem[rd_ptr].data : 8'h00;
      end
      uss_pkg::OFS_RX_STATUS: begin
        next_rdata = receive_status_control;
        next_rdata[uss_pkg::BIT_OVERRUN_ERROR_FLAG] = overrun_error_flag;
        // Ninth bit of the head word [RULE_02]
        next_rdata[uss_pkg::BIT_RECEIVED_NINTH_BIT] =
          (fifo_cnt != '0) && fifo_mem[rd_ptr].ninth;
      end
      uss_pkg::OFS_TX_STATUS: begin
        next_rdata = transmit_status_control;
        next_rdata[uss_pkg::BIT_TRMT] = !tx_busy;
      end
      uss_pkg::OFS_FLAGS: begin
        next_rdata[uss_pkg::BIT_RECEIVE_DONE_FLAG] = receive_done_flag;
        next_rdata[uss_pkg::BIT_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag;
      end
      uss_pkg::OFS_INT_ENABLE: next_rdata = int_enable;
      uss_pkg::OFS_EVT_STATUS: next_rdata = {5'h00, evt_status};
      uss_pkg::OFS_EVT_MASK: next_rdata = {5'h00, evt_mask};
      uss_pkg::OFS_ALT_PIN_A: next_rdata = alternate_pin_select_a;
      uss_pkg::OFS_ALT_PIN_B: next_rdata = alternate_pin_select_b;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : uss_core

// ===== common/uss_pkg.sv
// Shared constants and types for the synchronous slave transceiver
package uss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port
  localparam logic [3:0] OFS_BAUD_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RX_BUFFER = 4'h1;
  localparam logic [3:0] OFS_RX_STATUS = 4'h2;
  localparam logic [3:0] OFS_TX_STATUS = 4'h3;
  localparam logic [3:0] OFS_TX_HOLDING = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h5;
  localparam logic [3:0] OFS_INT_ENABLE = 4'h6;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h7;
  localparam logic [3:0] OFS_EVT_MASK = 4'h8;
  localparam logic [3:0] OFS_ALT_PIN_A = 4'h9;
  localparam logic [3:0] OFS_ALT_PIN_B = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_RX_IDLE = 6;      // baud_control, read only
  localparam int BIT_SCK_POL = 4;      // baud_control, clock polarity
  localparam int BIT_SERIAL_PORT_ENABLE = 7;         // receive_status_control
  localparam int BIT_RX9 = 6;
  localparam int BIT_SINGLE_RECEIVE_ENABLE = 5;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int BIT_OVERRUN_ERROR_FLAG = 1;
  localparam int BIT_RECEIVED_NINTH_BIT = 0;
  localparam int BIT_CLOCK_SOURCE_SELECT = 7;         // transmit_status_control
  localparam int BIT_TX9 = 6;
  localparam int BIT_TXEN = 5;
  localparam int BIT_SYNC = 4;
  localparam int BIT_TRMT = 1;
  localparam int BIT_TX9D = 0;
  localparam int BIT_RECEIVE_DONE_FLAG = 0;         // flags and int_enable
  localparam int BIT_TRANSMIT_EMPTY_FLAG = 1;
  localparam int BIT_PERIPHERAL_INTERRUPT_ENABLE = 2;         // int_enable only
  localparam int BIT_GIE = 3;
  localparam int EVT_RX_WORD = 0;      // evt_status and evt_mask
  localparam int EVT_TX_LOAD = 1;
  localparam int EVT_OVERRUN = 2;
  localparam int BIT_RXDT_SEL = 7;     // alternate_pin_select_a
  localparam int BIT_TXCK_SEL = 0;     // alternate_pin_select_b

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, sizes and fixed numbers
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [2:0] RST_EVT = 3'h0;
  localparam logic [3:0] LEN_BYTE = 4'h8;
  localparam logic [3:0] LEN_NINE = 4'h9;
  localparam int RX_FIFO_DEPTH = 2;
  localparam logic [11:0] ISR_VECTOR = 12'h004;

  // One received word as it sits in the receive FIFO
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } uss_word_t;

endpackage : uss_pkg

// ===== verif/uss_master_model.sv
`timescale 1ns/100ps
// External master: makes the shift clock, sends and takes words
module uss_master_model (
  // Link lines
  output logic ck,
  output logic dt,
  input wire logic dt_dev
);
  // Clock stands low outside frames
  initial begin
    ck = 1'b0;
    dt = 1'b0;
  end
  ////////////////////////////////////////
  // Send LSB first, one bit per 80 ns
  task send(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      dt = w[i];
      #20 ck = 1'b1;
      #40 ck = 1'b0;
      #20;
    end
    // Released line shows the inverse of the last bit
    dt = ~dt;
  endtask : send
  // Take bits just before each trailing edge
  task recv(output logic [8:0] w, input int n);
    w = 9'h000;
    for (int i = 0; i < n; i++) begin
      #20 ck = 1'b1;
      #40 w[i] = dt_dev;
      ck = 1'b0;
      #20;
    end
  endtask : recv
endmodule : uss_master_model

// ===== verif/uss_core_asserts.sv
`timescale 1ns/100ps
// Port checks for the transceiver
module uss_core_asserts #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Requests and pin enables
  input wire logic irq,
  input wire logic wake_req,
  input wire logic isr_call,
  input wire logic [11:0] isr_vector,
  input wire logic dt_a_oe,
  input wire logic dt_b_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  vector_value_a: assert property (
    isr_call |-> isr_vector == 12'h004) else $error("bad vector");
  vector_cause_a: assert property (
    isr_call |-> $past(wake_req) || $past(wake_req, 2))
    else $error("call without wake");
  pin_excl_a: assert property (
    !(dt_a_oe && dt_b_oe)) else $error("both data pins driven");
  wake_gate_a: assert property (
    (reg_wr && reg_addr == uss_pkg::OFS_INT_ENABLE && !reg_wdata[0]
    && reg_wdata[2:1] != 2'b11) ##1 !reg_wr |=> !wake_req)
    else $error("wake without enables");
  irq_mask_a: assert property (
    (reg_wr && reg_addr == uss_pkg::OFS_EVT_MASK && reg_wdata[2:0] == 3'h0)
    ##1 !reg_wr |=> !irq) else $error("irq while masked");
  unmapped_read_a: assert property (
    reg_rd && reg_addr == 4'hF |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  idle_read_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("stale read data");
  baud_reserved_a: assert property (
    reg_rd && reg_addr == uss_pkg::OFS_BAUD_CONTROL
    |=> (reg_rdata & 8'hAF) == 8'h00) else $error("reserved bit set");
  // Main scenarios reached
  cover property (isr_call);
  cover property (irq);
  cover property (dt_a_oe);
  cover property (dt_b_oe);
endmodule : uss_core_asserts

bind uss_core uss_core_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_uss_core_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .wake_req(wake_req),
  .isr_call(isr_call), .isr_vector(isr_vector), .dt_a_oe(dt_a_oe),
  .dt_b_oe(dt_b_oe));

// ===== verif/tb_usart_sync_slave_rx_tx_sleep.sv
`timescale 1ns/100ps
// Register level tests of the slave transceiver
module tb_usart_sync_slave_rx_tx_sleep;
  // Design side signals
  logic sys_clk, rst_n, reg_wr, reg_rd, core_sleep, loc;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic irq, wake_req, isr_call, dt_a_out, dt_a_oe, dt_b_out, dt_b_oe;
  logic [11:0] isr_vector;
  // Link lines and resolved pins
  logic m_ck, m_dt, ck_a_in, ck_b_in, dt_a_in, dt_b_in;
  logic [8:0] w;
  int fail_count, samples_checked;
  // Reset value table
  logic [3:0] ofs [0:9] = '{4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8,
    4'h9, 4'hA, 4'hF};
  logic [7:0] rst_v [0:9] = '{8'h40, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  // Clock routed to the selected location; master data reaches both, a driven pin wins
  assign ck_a_in = loc ? 1'b0 : m_ck;
  assign ck_b_in = loc ? m_ck : 1'b0;
  assign dt_a_in = dt_a_oe ? dt_a_out : m_dt;
  assign dt_b_in = dt_b_oe ? dt_b_out : m_dt;

  uss_core #(.FIFO_DEPTH(2)) u_uss_core (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sleep(core_sleep),
    .irq(irq), .wake_req(wake_req), .isr_call(isr_call),
    .isr_vector(isr_vector), .ck_a_in(ck_a_in), .ck_b_in(ck_b_in),
    .dt_a_in(dt_a_in), .dt_b_in(dt_b_in), .dt_a_out(dt_a_out),
    .dt_a_oe(dt_a_oe), .dt_b_out(dt_b_out), .dt_b_oe(dt_b_oe));
  uss_master_model u_uss_master_model (.ck(m_ck), .dt(m_dt),
    .dt_dev(loc ? dt_b_in : dt_a_in));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  // One-cycle write strobe
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  // Compare seen against expected
  task chk(input logic [11:0] s, input logic [11:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Read strobe, reply taken in the next cycle
  task rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk({4'h0, rv}, {4'h0, e});
  endtask : rchk
  // Counts and verdict
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  // Test sequence
  initial begin
    {rst_n, reg_wr, reg_rd, core_sleep, loc} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(ofs[i], rst_v[i]);
    $display("reset test done");
    // Nine-bit slave reception while asleep
    wr_reg(uss_pkg::OFS_TX_STATUS, 8'h10);
    wr_reg(uss_pkg::OFS_RX_STATUS, 8'hD0);
    wr_reg(uss_pkg::OFS_INT_ENABLE, 8'h09);
    wr_reg(uss_pkg::OFS_EVT_MASK, 8'h07);
    core_sleep <= 1'b1;
    rchk(uss_pkg::OFS_BAUD_CONTROL, 8'h00);
    u_uss_master_model.send(9'h1A5, 9);
    repeat (8) @(posedge sys_clk);
    #1;
    chk({1'b0, irq, wake_req, isr_call, isr_vector[7:0]}, 12'h704);
    chk(isr_vector, uss_pkg::ISR_VECTOR);
    rchk(uss_pkg::OFS_RX_STATUS, 8'hD1);
    u_uss_master_model.send(9'h05A, 9);
    u_uss_master_model.send(9'h0FF, 9);
    repeat (8) @(posedge sys_clk);
    rchk(uss_pkg::OFS_RX_STATUS, 8'hD3);
    rchk(uss_pkg::OFS_EVT_STATUS, 8'h05);
    rchk(uss_pkg::OFS_RX_BUFFER, 8'hA5);
    rchk(uss_pkg::OFS_RX_STATUS, 8'hD2);
    rchk(uss_pkg::OFS_RX_BUFFER, 8'h5A);
    rchk(uss_pkg::OFS_FLAGS, 8'h02);
    wr_reg(uss_pkg::OFS_RX_STATUS, 8'hC0);
    rchk(uss_pkg::OFS_RX_STATUS, 8'hC0);
    wr_reg(uss_pkg::OFS_RX_STATUS, 8'hE0);
    rchk(uss_pkg::OFS_BAUD_CONTROL, 8'h40);
    wr_reg(uss_pkg::OFS_EVT_STATUS, 8'h07);
    rchk(uss_pkg::OFS_EVT_STATUS, 8'h00);
    chk({11'h000, irq}, 12'h000);
    $display("receive test done");
    // Two bytes queued, shifted out during sleep
    wr_reg(uss_pkg::OFS_RX_STATUS, 8'h80);
    wr_reg(uss_pkg::OFS_TX_STATUS, 8'h30);
    wr_reg(uss_pkg::OFS_INT_ENABLE, 8'h06);
    wr_reg(uss_pkg::OFS_TX_HOLDING, 8'h3C);
    wr_reg(uss_pkg::OFS_TX_HOLDING, 8'hC3);
    rchk(uss_pkg::OFS_FLAGS, 8'h00);
    chk({11'h000, wake_req}, 12'h000);
    u_uss_master_model.recv(w, 8);
    chk({3'h0, w}, 12'h03C);
    repeat (8) @(posedge sys_clk);
    rchk(uss_pkg::OFS_FLAGS, 8'h02);
    chk({11'h000, wake_req}, 12'h001);
    u_uss_master_model.recv(w, 8);
    chk({3'h0, w}, 12'h0C3);
    repeat (8) @(posedge sys_clk);
    rchk(uss_pkg::OFS_TX_STATUS, 8'h32);
    wr_reg(uss_pkg::OFS_INT_ENABLE, 8'h02);
    repeat (4) @(posedge sys_clk);
    #1;
    chk({11'h000, wake_req}, 12'h000);
    $display("transmit test done");
    // Pins moved to the second location
    loc <= 1'b1;
    wr_reg(uss_pkg::OFS_ALT_PIN_A, 8'h80);
    wr_reg(uss_pkg::OFS_ALT_PIN_B, 8'h01);
    wr_reg(uss_pkg::OFS_TX_STATUS, 8'h71);
    wr_reg(uss_pkg::OFS_TX_HOLDING, 8'h96);
    repeat (6) @(posedge sys_clk);
    #1;
    chk({10'h000, dt_b_oe, dt_a_oe}, 12'h002);
    u_uss_master_model.recv(w, 9);
    chk({3'h0, w}, 12'h196);
    wr_reg(uss_pkg::OFS_EVT_MASK, 8'h00);
    repeat (4) @(posedge sys_clk);
    $display("pin location test done");
    end_of_test();
  end
  // Watchdog
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : tb_usart_sync_slave_rx_tx_sleep
